// ### design/pmc_config.sv
`timescale 1ns/1ns
// What this block does
// RULE_01: bit 7 picks button hold 8s or 15s
// RULE_02: bit 6 picks output two open-drain or push-pull
// RULE_03: bit 5 clear: pin one open-drain output
// RULE_04: bit 5 set: pin one input drives output two
// RULE_05: bits 4-3 set rising power-good delay only
// RULE_06: bit 2 tightens threshold and enables overvoltage
// RULE_07: software unlocks password before writes take effect
// RULE_08: routing set: level bits ignored for outputs
// RULE_09: delay timer restarts when supplies drop out
module pmc_config
  import pmc_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS          // clock cycles per millisecond
)(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,                  // register write strobe
  input wire logic [7:0] addr_i,             // register subaddress
  input wire logic [7:0] wdata_i,            // write data
  input wire logic unlock_i,                 // password sequence satisfied
  input wire logic [1:0] level_bits_i,       // output level bits, [0] pin one, [1] out two
  input wire logic pb_n_i,                   // push button pin, low when pressed
  input wire logic supplies_good_i,          // all monitored rails in range
  input wire logic over_voltage_i,           // any rail above its window
  input wire logic general_pin_one_i,        // pin one level
  output logic [7:0] rdata_o,                // read data
  output logic general_pin_one_o,
  output logic general_pin_one_oe_n_o,
  output logic general_output_two_o,
  output logic general_output_two_oe_n_o,
  output logic supervisor_tight_o,           // tight threshold to the comparators
  output logic power_good_o,                 // delayed power good
  output logic button_reset_o                // one-cycle forced reset request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int DIV_W = $clog2(CYC_MS + 1);

  typedef struct packed {
    logic [7:0] cfg;              // configuration register
    logic [1:0] pb_sync;          // button synchroniser
    logic [1:0] good_sync;        // supplies good synchroniser
    logic [1:0] ov_sync;          // overvoltage synchroniser
    logic [1:0] pin1_sync;        // pin one synchroniser
    logic [DIV_W-1:0] div;        // millisecond divider
    logic tick;                   // millisecond enable pulse
    logic hold_done_q;            // previous hold timer state
    logic [7:0] rdata;
    pmc_pin_type pin1;
    pmc_pin_type out2;
    logic tight;
    logic pg;
    logic btn_rst;
  } pmc_cfg_type;

  pmc_cfg_type st_ff;
  pmc_cfg_type nxt_st;

  logic hold_done;                // button held long enough
  logic pg_done;                  // power good delay expired
  logic [MS_W-1:0] hold_limit;    // selected hold time in ms
  logic [MS_W-1:0] pg_limit;      // selected delay in ms
  logic rails_ok;                 // rails in range, overvoltage if watched
  logic cfg_hit;                  // access addresses the register

  // ----------------------------------------------------------------
  // selections
  // ----------------------------------------------------------------
  // hold time and delay decode
  always_comb begin
    hold_limit = st_ff.cfg[BIT_HOLD] ? HOLD_LONG_MS : HOLD_SHORT_MS; // RULE_01
    case (st_ff.cfg[BIT_DLY_HI:BIT_DLY_LO])                          // RULE_05
      2'h0: pg_limit = MS_W'(PG_DLY0_MS);
      2'h1: pg_limit = MS_W'(PG_DLY1_MS);
      2'h2: pg_limit = MS_W'(PG_DLY2_MS);
      default: pg_limit = MS_W'(PG_DLY3_MS);
    endcase
  end

  // overvoltage only counts with the tight setting
  assign rails_ok = st_ff.good_sync[1] && !(st_ff.cfg[BIT_TIGHT] && st_ff.ov_sync[1]); // RULE_06
  assign cfg_hit = (addr_i == CFG_ADDR);

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // button hold timer, runs while the button is pressed
  pmc_ms_timer u_hold (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tick_i(st_ff.tick),
    .run_i(!st_ff.pb_sync[1]),
    .limit_i(hold_limit),
    .done_o(hold_done)
  );

  // power good delay, restarts on any dropout
  pmc_ms_timer u_pg (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tick_i(st_ff.tick),
    .run_i(rails_ok),
    .limit_i(pg_limit),
    .done_o(pg_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // synchronisers
    nxt_st.pb_sync = {st_ff.pb_sync[0], pb_n_i};
    nxt_st.good_sync = {st_ff.good_sync[0], supplies_good_i};
    nxt_st.ov_sync = {st_ff.ov_sync[0], over_voltage_i};
    nxt_st.pin1_sync = {st_ff.pin1_sync[0], general_pin_one_i};
    // millisecond divider
    if (st_ff.div == DIV_W'(CYC_MS - 1)) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + DIV_W'(1);
      nxt_st.tick = 1'b0;
    end
    // write only when unlocked
    if (wr_en_i && cfg_hit && unlock_i) begin                       // RULE_07
      nxt_st.cfg = wdata_i & CFG_KEEP_MASK;
    end
    // read back, other addresses answer zero
    nxt_st.rdata = cfg_hit ? st_ff.cfg : 8'h00;
    // pin one: input when routed, else open-drain output
    nxt_st.pin1.out = 1'b0;
    if (st_ff.cfg[BIT_ROUTE]) begin
      nxt_st.pin1.oe_n = 1'b1;                                      // RULE_04
    end else begin
      nxt_st.pin1.oe_n = level_bits_i[0];                           // RULE_03
    end
    // output two: level from pin one when routed, level bit otherwise
    if (st_ff.cfg[BIT_ROUTE]) begin
      nxt_st.out2.out = st_ff.pin1_sync[1];                         // RULE_08
    end else begin
      nxt_st.out2.out = level_bits_i[1];                            // RULE_03
    end
    if (st_ff.cfg[BIT_OUT2_DRV]) begin
      nxt_st.out2.oe_n = 1'b0;                                      // RULE_02
    end else begin
      nxt_st.out2.oe_n = nxt_st.out2.out;                           // RULE_02
      nxt_st.out2.out = 1'b0;
    end
    // supervisor
    nxt_st.tight = st_ff.cfg[BIT_TIGHT];                            // RULE_06
    nxt_st.pg = pg_done && rails_ok;                                // RULE_05
    // reset request on the edge of the hold timer
    nxt_st.hold_done_q = hold_done;
    nxt_st.btn_rst = hold_done && !st_ff.hold_done_q;               // RULE_01
  end

  // register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_ff <= '{cfg: CFG_RESET, pb_sync: 2'h3, pin1: '{out: 1'b0, oe_n: 1'b1},
                 out2: '{out: 1'b0, oe_n: 1'b1}, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = st_ff.rdata;
  assign general_pin_one_o = st_ff.pin1.out;
  assign general_pin_one_oe_n_o = st_ff.pin1.oe_n;
  assign general_output_two_o = st_ff.out2.out;
  assign general_output_two_oe_n_o = st_ff.out2.oe_n;
  assign supervisor_tight_o = st_ff.tight;
  assign power_good_o = st_ff.pg;
  assign button_reset_o = st_ff.btn_rst;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cfg_reset_val: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_05
    $past(!rstn_i) |-> st_ff.cfg == CFG_RESET)
    else $error("config not at reset value");

  chk_locked_write: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_07
    wr_en_i && cfg_hit && !unlock_i |=> $stable(st_ff.cfg))
    else $error("locked write changed config");

  chk_open_write: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_07
    wr_en_i && cfg_hit && unlock_i |=> st_ff.cfg == ($past(wdata_i) & CFG_KEEP_MASK))
    else $error("unlocked write not taken");

  chk_pin_one_input: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_04
    st_ff.cfg[BIT_ROUTE] |=> general_pin_one_oe_n_o)
    else $error("pin one driven while routed as input");

  chk_route_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_08
    st_ff.cfg[BIT_ROUTE] && !st_ff.cfg[BIT_OUT2_DRV]
      |=> general_output_two_oe_n_o == $past(st_ff.pin1_sync[1]))
    else $error("output two not following pin one");

  chk_pp_drive: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_02
    st_ff.cfg[BIT_OUT2_DRV] |=> !general_output_two_oe_n_o)
    else $error("push-pull output released");

  chk_od_level: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_03
    !st_ff.cfg[BIT_ROUTE] && !st_ff.cfg[BIT_OUT2_DRV]
      |=> general_output_two_oe_n_o == $past(level_bits_i[1]) && !general_output_two_o)
    else $error("open-drain output two wrong");

  chk_pg_fall: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_05
    !st_ff.good_sync[1] |=> !power_good_o)
    else $error("power good not dropped at once");

  chk_pg_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_09
    $rose(power_good_o) |-> $past(pg_done) && $past(rails_ok))
    else $error("power good rose before delay");

  chk_button_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_01
    button_reset_o |=> !button_reset_o ##1 !button_reset_o)
    else $error("button reset not a single pulse");

  chk_tight_out: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_06
    st_ff.cfg[BIT_TIGHT] |=> supervisor_tight_o)
    else $error("tight select not passed out");

endmodule

// ### design/pmc_ms_timer.sv
`timescale 1ns/1ns
module pmc_ms_timer
  import pmc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic tick_i,                  // one pulse per millisecond
  input wire logic run_i,                   // count while high, clear when low
  input wire logic [MS_W-1:0] limit_i,      // target in milliseconds
  output logic done_o                       // high once limit reached while running
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MS_W-1:0] cnt;  // elapsed milliseconds
    logic done;            // target reached
  } pmc_tmr_type;

  pmc_tmr_type st_ff;
  pmc_tmr_type nxt_st;

  // next state: any drop of run restarts from zero
  always_comb begin
    nxt_st = st_ff;
    if (!run_i) begin
      nxt_st.cnt = '0;                      // RULE_09
    end else if (tick_i && (st_ff.cnt < limit_i)) begin
      nxt_st.cnt = st_ff.cnt + MS_W'(1);
    end
    nxt_st.done = run_i && (st_ff.cnt >= limit_i);
  end

  // register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;

  // done only follows a full count with run held
  chk_done_count: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_09
    $rose(done_o) |-> $past(run_i) && ($past(st_ff.cnt) >= $past(limit_i)))
    else $error("timer done without full count");

endmodule

// ### design/pmc_pkg.sv
package pmc_pkg;

  // ----------------------------------------------------------------
  // register placement and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'h13;   // subaddress of the config register
  localparam logic [7:0] CFG_RESET = 8'h4C;  // value after reset
  localparam logic [7:0] CFG_KEEP_MASK = 8'hFC; // threshold bits 1:0 not held here
  localparam int BIT_HOLD = 7;               // button hold time select
  localparam int BIT_OUT2_DRV = 6;           // out_two_driver_type
  localparam int BIT_ROUTE = 5;              // pin_one_routing_select
  localparam int BIT_DLY_HI = 4;             // good_assert_delay msb
  localparam int BIT_DLY_LO = 3;             // good_assert_delay lsb
  localparam int BIT_TIGHT = 2;              // supervisor_tight_select

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;         // 25 MHz clock
  localparam int MS_NS = 1000000;            // one millisecond in ns
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int S_MS = 1000;                // one second in ms
  localparam int HOLD_SHORT_S = 8;           // button hold, bit clear
  localparam int HOLD_LONG_S = 15;           // button hold, bit set
  localparam int PG_DLY0_MS = 10;
  localparam int PG_DLY1_MS = 20;
  localparam int PG_DLY2_MS = 50;
  localparam int PG_DLY3_MS = 150;
  localparam int MS_W = 16;                  // width of millisecond counts
  localparam logic [MS_W-1:0] HOLD_SHORT_MS = MS_W'(HOLD_SHORT_S * S_MS);
  localparam logic [MS_W-1:0] HOLD_LONG_MS = MS_W'(HOLD_LONG_S * S_MS);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out;     // level driven when enabled
    logic oe_n;    // low while the pin is driven
  } pmc_pin_type;

endpackage

// ### dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pmc_pkg::*;
  // ----------------------------------------------------------------
  // signals and notes
  // ----------------------------------------------------------------
  localparam int C = 2;                 // clock cycles per ms in this run
  typedef struct {
    int kind;                           // 0 sampled value, 1 good edge, 2 button pulse
    int lo;                             // expected value or lowest count
    int hi;                             // mask or highest count
  } pmc_note_type;
  pmc_note_type notes[$];               // oldest expectation first
  logic mclk_i = 0, rstn_i = 0, wr = 0, unl = 0, pb_n = 1, sg = 0, ov = 0;
  logic p1in = 1, chk = 0, sg_q = 0, ov_q = 0, pb_q = 1, pg_q = 0;
  logic [1:0] lv = 2'h3;                // output level bits
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, cfg;
  logic p1o, p1oe_n, o2o, o2oe_n, tight, pg, btn, pin_lvl;
  logic [15:0] obs;                     // every output level but the button reset, seen at a sample point
  int fails = 0, tests_run = 0, cyc = 0, since_in = 0, since_pb = 0;
  int dly_ms[4] = '{10, 20, 50, 150};   // power good delays per code
  logic [31:0] seed = 32'h00000011;
  assign pin_lvl = (p1oe_n === 1'b0) ? p1o : p1in; // wire level of pin one
  assign obs = {rdata, tight, pg, p1o, p1oe_n, o2o, o2oe_n, 2'h0};
  always #20 mclk_i = ~mclk_i;
  pmc_config #(.CYC_MS(C)) pmc_config_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .wr_en_i(wr), .addr_i(addr), .wdata_i(wd),
    .unlock_i(unl), .level_bits_i(lv), .pb_n_i(pb_n), .supplies_good_i(sg),
    .over_voltage_i(ov), .general_pin_one_i(pin_lvl), .rdata_o(rdata),
    .general_pin_one_o(p1o), .general_pin_one_oe_n_o(p1oe_n),
    .general_output_two_o(o2o), .general_output_two_oe_n_o(o2oe_n),
    .supervisor_tight_o(tight), .power_good_o(pg), .button_reset_o(btn));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic step(int k);
    repeat (k) @(posedge mclk_i);
  endtask
  task automatic cmp_val(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic cmp_rng(int got, int lo, int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      fails++;
    end
  endtask
  // one write cycle; the bench model keeps what the register should hold
  task automatic wr_cfg(logic [7:0] d, logic u, logic [7:0] a);
    wr <= 1;
    addr <= a;
    wd <= d;
    unl <= u;
    @(posedge mclk_i);
    wr <= 0;
    if (u && a == CFG_ADDR) cfg = d & CFG_KEEP_MASK;
  endtask
  // let levels settle, then note what every output but the button reset should show
  task automatic check(logic [7:0] ra, logic pg_exp);
    logic route, pp, src;
    route = cfg[BIT_ROUTE];
    pp = cfg[BIT_OUT2_DRV];
    addr <= ra;
    step(6);
    src = route ? p1in : lv[1];
    notes.push_back('{0, {(ra == CFG_ADDR) ? cfg : 8'h00, cfg[BIT_TIGHT], pg_exp, 1'b0,
      route | lv[0], pp & src, ~pp & src, 2'h0}, 16'hFFFF});
    chk <= 1;
    step(1);
    chk <= 0;
  endtask
  task automatic wait_pg(logic v);
    for (int k = 0; k < 400 && pg !== v; k++) step(1);
    // a wait that runs out counts as a mismatch
    cmp_val({15'h0000, pg}, {15'h0000, v});
  endtask
  task automatic pg_up(int ms);
    notes.push_back('{1, (ms - 1) * C, (ms + 1) * C + 8});
    sg <= 1;
    wait_pg(1);
  endtask
  task automatic results();
    if (notes.size() != 0) fails++;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watcher: takes the oldest note whenever a result shows up
  // ----------------------------------------------------------------
  always @(negedge mclk_i) begin
    pmc_note_type n;
    int ev;
    since_in = (sg != sg_q || ov != ov_q) ? 0 : since_in + 1;
    since_pb = (pb_n != pb_q) ? 0 : since_pb + 1;
    sg_q = sg;
    ov_q = ov;
    pb_q = pb_n;
    if (rstn_i && (chk || pg !== pg_q || btn !== 1'b0)) begin
      ev = chk ? 0 : (btn !== 1'b0) ? 2 : 1;
      if (notes.size() == 0) begin
        cmp_rng(ev, -1, -1);
      end else begin
        n = notes.pop_front();
        cmp_rng(ev, n.kind, n.kind);
        if (ev == 0) cmp_val(obs & n.hi[15:0], n.lo[15:0]);
        if (ev == 1) cmp_rng(since_in, n.lo, n.hi);
        if (ev == 2) cmp_rng(since_pb, n.lo, n.hi);
      end
    end
    pg_q = pg;
  end
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    cfg = CFG_RESET;
    step(2);
    rstn_i <= 1;
    check(CFG_ADDR, 1'b0);
    // random writes, locked or not, any address, random pin levels
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      wr_cfg(r[7:0], r[8], r[9] ? CFG_ADDR : r[23:16]);
      lv <= r[11:10];
      p1in <= r[12];
      check(r[13] ? CFG_ADDR : r[31:24], 1'b0);
    end
    // every delay code, rising delayed, falling not
    for (int d = 0; d < 4; d++) begin
      wr_cfg({3'b010, d[1:0], 3'b100}, 1'b1, CFG_ADDR);
      pg_up(dly_ms[d]);
      sg <= 0;
      notes.push_back('{1, 1, 4});
      wait_pg(0);
    end
    // a dropout before expiry restarts the whole delay
    wr_cfg(8'h54, 1'b1, CFG_ADDR);
    sg <= 1;
    step(60);
    sg <= 0;
    step(6);
    pg_up(50);
    // overvoltage drops good only while tight
    ov <= 1;
    notes.push_back('{1, 1, 4});
    wait_pg(0);
    ov <= 0;
    pg_up(50);
    wr_cfg(8'h50, 1'b1, CFG_ADDR);
    step(4);
    ov <= 1;
    step(20);
    check(CFG_ADDR, 1'b1);
    ov <= 0;
    sg <= 0;
    notes.push_back('{1, 1, 4});
    wait_pg(0);
    // button: short press restarts, then full 8 s and 15 s holds
    wr_cfg(8'h4C, 1'b1, CFG_ADDR);
    pb_n <= 0;
    step(3000);
    pb_n <= 1;
    step(6);
    pb_n <= 0;
    notes.push_back('{2, 7999 * C, 8001 * C + 8});
    step(8000 * C + 300);
    pb_n <= 1;
    wr_cfg(8'hCC, 1'b1, CFG_ADDR);
    step(6);
    pb_n <= 0;
    notes.push_back('{2, 14999 * C, 15001 * C + 8});
    step(15000 * C + 300);
    pb_n <= 1;
    step(4);
    results();
  end
endmodule
